// [logic/tcpm_pkg.sv]
// tcpm_pkg: offsets, fields, resets, rates and types of the channel 0 shared pin mux
// assumes a 50 MHz bus clock and a 32-bit AHB-Lite register port
package tcpm_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HDLC_DIV = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_TRIB_EDGES = 8'h0C;
    // control field positions
    localparam int CTRL_ADD_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_TRIB_OUT = 3;
    localparam int CTRL_TYPE_LO = 4;
    // status field positions
    localparam int STAT_ROLE3_LO = 0;
    localparam int STAT_ROLE4_LO = 3;
    localparam int STAT_ADD_LO = 6;
    localparam int STAT_HDLC_LO = 8;
    localparam int STAT_OVH = 10;
    // reset values
    localparam logic [7:0] HDLC_HALF_RST = 8'h04;
    // clock rates in kHz
    localparam int HCLK_KHZ = 50000;
    localparam int RATE_E3_KHZ = 34368;
    localparam int RATE_DS3_KHZ = 44736;
    localparam int RATE_STS1_KHZ = 51840;
    // half period in bus clocks, rounded down, never below one
    function automatic int half_count(input int rate_khz);
        int n;
        n = HCLK_KHZ / (2 * rate_khz);
        return (n < 1) ? 1 : n;
    endfunction
    localparam logic [7:0] TRIB_HALF_E3 = 8'(half_count(RATE_E3_KHZ));
    localparam logic [7:0] TRIB_HALF_DS3 = 8'(half_count(RATE_DS3_KHZ));
    localparam logic [7:0] TRIB_HALF_STS1 = 8'(half_count(RATE_STS1_KHZ));
    // operating modes, tributary signal types and pin roles
    typedef enum logic [1:0] {MODE_HDLC = 2'h0, MODE_MAPPER = 2'h1, MODE_FRAMER = 2'h2, MODE_IDLE = 2'h3}
        tcpm_mode_type;
    typedef enum logic [1:0] {TYPE_DS3 = 2'h0, TYPE_E3 = 2'h1, TYPE_STS1 = 2'h2, TYPE_RSV = 2'h3}
        tcpm_trib_type;
    typedef enum logic [2:0] {ROLE_ADD = 3'h0, ROLE_HDLC = 3'h1, ROLE_TRIB = 3'h3, ROLE_OVH = 3'h2,
        ROLE_NONE = 3'h6} tcpm_role_type;
endpackage

// [logic/tcpm_sync.sv]
// tcpm_sync: two flip-flop synchroniser for levels
// assumes each bit is an independent level or a toggle
`timescale 1ns/10ps
module tcpm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // level in and synchronised level out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } tcpm_sync_state_type;
    tcpm_sync_state_type r;
    tcpm_sync_state_type next_r;

    // first stage feeds only the second stage
    always_comb
    begin
        next_r.first = d;
        next_r.second = r.first;
    end

    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign q = r.second;
endmodule // tcpm_sync

// [logic/tcpm_add_capture.sv]
// tcpm_add_capture: add bus bits 3 and 4 taken on the falling add bus clock
// assumes the add bus clock may stop; words leave by a toggle handshake
`timescale 1ns/10ps
module tcpm_add_capture
    import tcpm_pkg::*;
(
    // link clock and reset
    input wire logic add_clk,
    input wire logic hresetn,
    // bus side controls
    input wire logic add_en,
    input wire logic ack_toggle,
    // pins and captured word
    input wire logic [1:0] pin_bits,
    output logic req_toggle,
    output logic [1:0] bits
);
    typedef struct packed {
        logic req;
        logic [1:0] bits;
    } tcpm_cap_state_type;
    tcpm_cap_state_type r;
    tcpm_cap_state_type next_r;
    logic [1:0] ctl_s;

    // enable and acknowledge brought onto the link clock
    tcpm_sync #(.WIDTH(2)) u_ctl_sync (
        .clk(add_clk),
        .resetn(hresetn),
        .d({add_en, ack_toggle}),
        .q(ctl_s)
    );

    // new word only once the previous one was acknowledged
    always_comb
    begin
        next_r = r;
        if (ctl_s[1] && (ctl_s[0] == r.req))
        begin
            next_r.bits = pin_bits;
            next_r.req = ~r.req;
        end
    end

    // bits latched on the falling edge
    always_ff @(negedge add_clk or negedge hresetn)
    begin
        if (!hresetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign req_toggle = r.req;
    assign bits = r.bits;
endmodule // tcpm_add_capture

// [logic/tcpm_top.sv]
// tcpm_top: role selection and timing of channel 0 shared transmit pins 3 and 4
// assumes one AHB-Lite slave select, a free add bus clock port and a framer core on hclk
//
// Function
// - add bus enable decides pin roles first
// - add bus on: pins are add data bits
// - add bits taken on falling add clock
// - add bus off: mode picks each role
// - HDLC mode: bit 3 and bit 4 pins are HDLC bits
// - drive HDLC clock, sample on rising edge
// - mapper input: accept tributary clock, add signal
// - mapper output: drop channel through tributary port
// - mapper output: drive tributary clock at half hclk rate, every type's half period rounds to one
// - framer mode: bit 4 drives overhead indicator
`timescale 1ns/10ps
module tcpm_top
    import tcpm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // add bus clock
    input wire logic add_bus_ch0_clock,
    // shared pin 3
    input wire logic shared_d3_in,
    output logic shared_d3_out,
    output logic shared_d3_oe,
    // shared pin 4
    input wire logic shared_d4_in,
    output logic shared_d4_out,
    output logic shared_d4_oe,
    // HDLC transmit clock pin
    output logic hdlc_tx_ch0_clock,
    // framer core side
    input wire logic tx_overhead_indicator_ch0,
    output logic add_bits_valid,
    output logic add_bus_ch0_bit3,
    output logic add_bus_ch0_bit4,
    output logic hdlc_byte_strobe,
    output logic hdlc_tx_ch0_bit3,
    output logic hdlc_tx_ch0_bit4,
    output logic trib_add_strobe,
    output logic trib_drop_strobe
);
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic add_en;
        tcpm_mode_type mode;
        logic trib_out;
        tcpm_trib_type ttype;
        logic [7:0] hdlc_half;
        logic [7:0] hdlc_cnt;
        logic hdlc_clk;
        logic [7:0] trib_cnt;
        logic trib_clk;
        logic trib_prev;
        logic [15:0] trib_edges;
        logic ack;
        logic add_valid;
        logic [1:0] add_bits;
        logic hdlc_strobe;
        logic [1:0] hdlc_bits;
        logic add_strobe;
        logic drop_strobe;
        logic d3_out;
        logic d3_oe;
        logic d4_out;
        logic d4_oe;
    } tcpm_state_type;

    tcpm_state_type r;
    tcpm_state_type next_r;
    tcpm_role_type role3;
    tcpm_role_type role4;
    logic [1:0] pins_s;
    logic req_s;
    logic link_req;
    logic [1:0] link_bits;
    logic [7:0] trib_half;
    logic hdlc_wrap;
    logic trib_wrap;
    logic trib_rise_in;

    // role of one shared pin from add enable and mode
    function automatic tcpm_role_type role_of(input logic add_en, input tcpm_mode_type mode,
        input logic is_bit4);
        tcpm_role_type role;
        role = ROLE_NONE;
        if (add_en)
            role = ROLE_ADD;
        else
        begin
            case (mode)
                MODE_HDLC: role = ROLE_HDLC;
                MODE_MAPPER: role = is_bit4 ? ROLE_NONE : ROLE_TRIB;
                MODE_FRAMER: role = is_bit4 ? ROLE_OVH : ROLE_NONE;
                default: role = ROLE_NONE;
            endcase
        end
        return role;
    endfunction

    // divider terminal count, a zero or one half period counts as one
    function automatic logic at_wrap(input logic [7:0] cnt, input logic [7:0] half);
        return (half <= 8'h01) || (cnt >= half - 8'h01);
    endfunction

    // shared pins brought onto the bus clock
    tcpm_sync #(.WIDTH(2)) u_pin_sync (
        .clk(hclk),
        .resetn(hresetn),
        .d({shared_d4_in, shared_d3_in}),
        .q(pins_s)
    );

    // add bus capture on the link clock
    tcpm_add_capture u_add_capture (
        .add_clk(add_bus_ch0_clock),
        .hresetn(hresetn),
        .add_en(r.add_en),
        .ack_toggle(r.ack),
        .pin_bits({shared_d4_in, shared_d3_in}),
        .req_toggle(link_req),
        .bits(link_bits)
    );

    // capture request toggle brought onto the bus clock
    tcpm_sync #(.WIDTH(1)) u_req_sync (
        .clk(hclk),
        .resetn(hresetn),
        .d(link_req),
        .q(req_s)
    );

    // decoded roles and divider terms
    always_comb
    begin
        role3 = role_of(r.add_en, r.mode, 1'b0);
        role4 = role_of(r.add_en, r.mode, 1'b1);
        case (r.ttype)
            TYPE_E3: trib_half = TRIB_HALF_E3;
            TYPE_STS1: trib_half = TRIB_HALF_STS1;
            default: trib_half = TRIB_HALF_DS3;
        endcase
        hdlc_wrap = at_wrap(r.hdlc_cnt, r.hdlc_half);
        trib_wrap = at_wrap(r.trib_cnt, trib_half);
        trib_rise_in = pins_s[0] && !r.trib_prev;
    end

    // next state of the whole block
    always_comb
    begin
        next_r = r;
        next_r.hreadyout = 1'b1;
        next_r.hresp = 1'b0;
        next_r.wr_pend = 1'b0;
        next_r.add_valid = 1'b0;
        next_r.hdlc_strobe = 1'b0;
        next_r.add_strobe = 1'b0;
        next_r.drop_strobe = 1'b0;
        next_r.trib_prev = pins_s[0];

        // write data phase
        if (r.wr_pend)
        begin
            case (r.wr_addr)
                REG_CTRL:
                begin
                    next_r.add_en = hwdata[CTRL_ADD_EN];
                    next_r.mode = tcpm_mode_type'(hwdata[CTRL_MODE_LO +: 2]);
                    next_r.trib_out = hwdata[CTRL_TRIB_OUT];
                    next_r.ttype = tcpm_trib_type'(hwdata[CTRL_TYPE_LO +: 2]);
                end
                REG_HDLC_DIV: next_r.hdlc_half = hwdata[7:0];
                REG_TRIB_EDGES: next_r.trib_edges = 16'h0000;
                default: next_r.wr_pend = 1'b0;
            endcase
        end

        // address phase, reads answered in the following data phase
        if (hsel && hready && htrans[1])
        begin
            next_r.hrdata = 32'h0000_0000;
            if (haddr[31:8] == 24'h00_0000)
            begin
                next_r.wr_pend = hwrite;
                next_r.wr_addr = {haddr[7:2], 2'b00};
                if (!hwrite)
                begin
                    case ({haddr[7:2], 2'b00})
                        REG_CTRL:
                        begin
                            next_r.hrdata[CTRL_ADD_EN] = r.add_en;
                            next_r.hrdata[CTRL_MODE_LO +: 2] = r.mode;
                            next_r.hrdata[CTRL_TRIB_OUT] = r.trib_out;
                            next_r.hrdata[CTRL_TYPE_LO +: 2] = r.ttype;
                        end
                        REG_HDLC_DIV: next_r.hrdata[7:0] = r.hdlc_half;
                        REG_STATUS:
                        begin
                            next_r.hrdata[STAT_ROLE3_LO +: 3] = role3;
                            next_r.hrdata[STAT_ROLE4_LO +: 3] = role4;
                            next_r.hrdata[STAT_ADD_LO +: 2] = r.add_bits;
                            next_r.hrdata[STAT_HDLC_LO +: 2] = r.hdlc_bits;
                            next_r.hrdata[STAT_OVH] = r.d4_out;
                        end
                        REG_TRIB_EDGES: next_r.hrdata[15:0] = r.trib_edges;
                        default: next_r.hrdata = 32'h0000_0000;
                    endcase
                end
            end
        end

        // add bus word accepted once per link request
        if (req_s != r.ack)
        begin
            next_r.ack = req_s;
            if (role3 == ROLE_ADD)
            begin
                next_r.add_bits = link_bits;
                next_r.add_valid = 1'b1;
            end
        end

        // HDLC byte clock, bits taken as the clock rises
        if (role4 == ROLE_HDLC)
        begin
            next_r.hdlc_cnt = hdlc_wrap ? 8'h00 : r.hdlc_cnt + 8'h01;
            if (hdlc_wrap)
            begin
                next_r.hdlc_clk = ~r.hdlc_clk;
                if (!r.hdlc_clk)
                begin
                    next_r.hdlc_bits = pins_s;
                    next_r.hdlc_strobe = 1'b1;
                end
            end
        end
        else
        begin
            next_r.hdlc_cnt = 8'h00;
            next_r.hdlc_clk = 1'b0;
        end

        // tributary clock, received or generated
        next_r.trib_cnt = 8'h00;
        next_r.trib_clk = 1'b0;
        if (role3 == ROLE_TRIB)
        begin
            if (r.trib_out)
            begin
                next_r.trib_cnt = trib_wrap ? 8'h00 : r.trib_cnt + 8'h01;
                next_r.trib_clk = trib_wrap ? ~r.trib_clk : r.trib_clk;
                if (trib_wrap && !r.trib_clk)
                begin
                    next_r.drop_strobe = 1'b1;
                    next_r.trib_edges = next_r.trib_edges + 16'h0001;
                end
            end
            else if (trib_rise_in)
            begin
                next_r.add_strobe = 1'b1;
                next_r.trib_edges = next_r.trib_edges + 16'h0001;
            end
        end

        // pin drivers, on only in output roles
        next_r.d3_oe = (role3 == ROLE_TRIB) && r.trib_out;
        next_r.d3_out = next_r.d3_oe && next_r.trib_clk;
        next_r.d4_oe = (role4 == ROLE_OVH);
        next_r.d4_out = next_r.d4_oe && tx_overhead_indicator_ch0;
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0;
            r.hreadyout <= 1'b1;
            r.mode <= MODE_IDLE;
            r.hdlc_half <= HDLC_HALF_RST;
        end
        else
            r <= next_r;
    end

    // outputs straight from the state register
    assign hreadyout = r.hreadyout;
    assign hresp = r.hresp;
    assign hrdata = r.hrdata;
    assign shared_d3_out = r.d3_out;
    assign shared_d3_oe = r.d3_oe;
    assign shared_d4_out = r.d4_out;
    assign shared_d4_oe = r.d4_oe;
    assign hdlc_tx_ch0_clock = r.hdlc_clk;
    assign add_bits_valid = r.add_valid;
    assign add_bus_ch0_bit3 = r.add_bits[0];
    assign add_bus_ch0_bit4 = r.add_bits[1];
    assign hdlc_byte_strobe = r.hdlc_strobe;
    assign hdlc_tx_ch0_bit3 = r.hdlc_bits[0];
    assign hdlc_tx_ch0_bit4 = r.hdlc_bits[1];
    assign trib_add_strobe = r.add_strobe;
    assign trib_drop_strobe = r.drop_strobe;
endmodule // tcpm_top

// [verification/tcpm_asserts.sv]
// tcpm_asserts: port timing checks of the channel 0 shared pin mux
// assumes binding into tcpm_top, one hclk domain and active low hresetn
`timescale 1ns/10ps
module tcpm_asserts (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // watched ports
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic shared_d3_in,
    input wire logic shared_d3_out,
    input wire logic shared_d3_oe,
    input wire logic shared_d4_out,
    input wire logic shared_d4_oe,
    input wire logic hdlc_tx_ch0_clock,
    input wire logic tx_overhead_indicator_ch0,
    input wire logic add_bits_valid,
    input wire logic hdlc_byte_strobe,
    input wire logic trib_add_strobe,
    input wire logic trib_drop_strobe
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // bus answers at once with okay
    bus_ready_a: assert property (hreadyout) else $error("hreadyout low");
    bus_okay_a: assert property (!hresp) else $error("hresp not okay");
    // overhead pin repeats the framer indicator one cycle later
    ovh_follow_a: assert property (
        shared_d4_oe |-> shared_d4_out == $past(tx_overhead_indicator_ch0)) else $error("overhead pin wrong");
    // hdlc byte sampled at the rise of the driven clock, one byte per period
    hdlc_edge_a: assert property (
        hdlc_byte_strobe |-> $rose(hdlc_tx_ch0_clock)) else $error("hdlc sample off edge");
    hdlc_rate_a: assert property (
        hdlc_byte_strobe |=> (!hdlc_byte_strobe) [*7]) else $error("hdlc period short");
    hdlc_pins_a: assert property (
        hdlc_byte_strobe |-> !shared_d3_oe && !shared_d4_oe) else $error("pin driven in hdlc role");
    // dropped tributary clock toggles every cycle while driven
    drop_edge_a: assert property (
        trib_drop_strobe |-> ##[0:1] (shared_d3_oe && $rose(shared_d3_out))) else $error("drop strobe off edge");
    trib_rate_a: assert property (
        shared_d3_oe && $past(shared_d3_oe) && $past(shared_d3_oe, 2) |-> shared_d3_out != $past(shared_d3_out))
        else $error("tributary clock rate wrong");
    // added tributary edge follows a high pin
    trib_sample_a: assert property (
        trib_add_strobe |-> $past(shared_d3_in, 2) || $past(shared_d3_in, 3) || $past(shared_d3_in, 4))
        else $error("add strobe without edge");
    cover property (add_bits_valid);
    cover property (hdlc_byte_strobe);
    cover property (trib_add_strobe);
    cover property (trib_drop_strobe);
endmodule // tcpm_asserts

bind tcpm_top tcpm_asserts u_asserts (.hclk, .hresetn, .hreadyout, .hresp, .shared_d3_in, .shared_d3_out,
    .shared_d3_oe, .shared_d4_out, .shared_d4_oe, .hdlc_tx_ch0_clock, .tx_overhead_indicator_ch0,
    .add_bits_valid, .hdlc_byte_strobe, .trib_add_strobe, .trib_drop_strobe);

// [verification/tcpm_far_end.sv]
// tcpm_far_end: system side equipment offering values to shared pins 3 and 4
// assumes the bench picks the role and resolves pins against the block's enables
`timescale 1ns/10ps
module tcpm_far_end (
    // clocks seen at the far end
    input wire logic add_bus_ch0_clock,
    input wire logic hclk,
    input wire logic hdlc_tx_ch0_clock,
    // role 0 add, 1 hdlc, 2 tributary, 3 released; word is {bit4, bit3}, word[0] runs tributary clock
    input wire logic [1:0] role,
    input wire logic [1:0] word,
    // values offered to pins {4, 3}
    output logic [1:0] pins
);
    logic [1:0] add_q = 2'h0;
    logic [1:0] hdlc_q = 2'h0;
    logic [1:0] free_q = 2'h1;
    logic trib_clk = 1'b0;
    // add data changes on the rise, settled for the falling capture
    always @(posedge add_bus_ch0_clock)
        add_q <= word;
    // hdlc data changes on the fall, settled for the rising sample
    always @(negedge hdlc_tx_ch0_clock)
        hdlc_q <= word;
    // tributary clock, slowed so the bus clock can see it, still outside frames
    always #30 trib_clk = (role == 2'h2 && word[0]) ? !trib_clk : 1'b0;
    // released lines change every cycle
    always @(posedge hclk)
        free_q <= ~free_q;
    // pick what the pins carry
    always_comb
        case (role)
            2'h0: pins = add_q;
            2'h1: pins = hdlc_q;
            2'h2: pins = {free_q[1], trib_clk};
            default: pins = free_q;
        endcase
endmodule // tcpm_far_end

// [verification/tx_ch0_shared_pin_mux_tb.sv]
// tx_ch0_shared_pin_mux_tb: directed tests of the channel 0 shared pin mux
// assumes tcpm_top, the far end model and the bound checker
`timescale 1ns/10ps
module tx_ch0_shared_pin_mux_tb
    import tcpm_pkg::*;
;
    localparam logic [31:0] A_CTRL = {24'h0, REG_CTRL};
    localparam logic [31:0] A_DIV = {24'h0, REG_HDLC_DIV};
    localparam logic [31:0] A_STAT = {24'h0, REG_STATUS};
    localparam logic [31:0] A_EDGE = {24'h0, REG_TRIB_EDGES};
    logic hclk = 1'b0, add_bus_ch0_clock = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0, role = 2'h3, word = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic tx_overhead_indicator_ch0 = 1'b0;
    wire logic hready, hreadyout, hresp, shared_d3_in, shared_d3_out, shared_d3_oe;
    wire logic shared_d4_in, shared_d4_out, shared_d4_oe, hdlc_tx_ch0_clock, add_bits_valid;
    wire logic add_bus_ch0_bit3, add_bus_ch0_bit4, hdlc_byte_strobe, hdlc_tx_ch0_bit3, hdlc_tx_ch0_bit4;
    wire logic trib_add_strobe, trib_drop_strobe;
    wire logic [31:0] hrdata;
    wire logic [1:0] pins;
    int num_errors = 0, num_checks = 0;
    int sent = 0;
    // rising tributary clock edges that the far end really offered on pin 3
    always @(posedge pins[0])
        if (role == 2'h2)
            sent++;
    // clocks, bus ready and pin resolution
    always #10 hclk = ~hclk;
    initial #3.3 forever #7.5 add_bus_ch0_clock = ~add_bus_ch0_clock;
    assign hready = hreadyout;
    assign shared_d3_in = shared_d3_oe ? shared_d3_out : pins[0];
    assign shared_d4_in = shared_d4_oe ? shared_d4_out : pins[1];
    tcpm_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
        .hresp, .hrdata, .add_bus_ch0_clock, .shared_d3_in, .shared_d3_out, .shared_d3_oe, .shared_d4_in,
        .shared_d4_out, .shared_d4_oe, .hdlc_tx_ch0_clock, .tx_overhead_indicator_ch0, .add_bits_valid,
        .add_bus_ch0_bit3, .add_bus_ch0_bit4, .hdlc_byte_strobe, .hdlc_tx_ch0_bit3, .hdlc_tx_ch0_bit4,
        .trib_add_strobe, .trib_drop_strobe);
    tcpm_far_end far (.add_bus_ch0_clock, .hclk, .hdlc_tx_ch0_clock, .role, .word, .pins);
    task automatic summarize;
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        check({31'h0, got}, {31'h0, exp}, what);
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
        check_bit(hresp, 1'b0, "bus response");
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        bus(a, 1'b0, 32'h0, d);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // wait for an add word (0) or an hdlc byte (1)
    task automatic wait_for(input int k);
        int n;
        n = 0;
        do
        begin
            step(1);
            n++;
        end
        while (((k == 0) ? add_bits_valid : hdlc_byte_strobe) !== 1'b1 && n < 300);
        check_bit(n < 300, 1'b1, "pulse seen");
    endtask
    task automatic t_regs;
        logic [31:0] v;
        rd(A_CTRL, v);
        check(v, 32'h6, "ctrl reset");
        rd(A_DIV, v);
        check(v, 32'h4, "div reset");
        wr(A_STAT, 32'hFFFF_FFFF);
        rd(A_STAT, v);
        check(v, {26'h0, ROLE_NONE, ROLE_NONE}, "status idle");
        wr(A_DIV, 32'h55);
        rd(A_DIV, v);
        check(v, 32'h55, "div rw");
        wr(A_DIV, 32'h4);
        wr(32'h100, 32'h1);
        rd(32'h100, v);
        check(v, 32'h0, "unmapped");
    endtask
    task automatic t_add;
        logic [31:0] v;
        role <= 2'h0;
        word <= 2'h2;
        wr(A_CTRL, 32'h5);
        wait_for(0);
        wait_for(0);
        check({30'h0, add_bus_ch0_bit4, add_bus_ch0_bit3}, 32'h2, "add word");
        check_bit(shared_d3_oe | shared_d4_oe, 1'b0, "add oe");
        rd(A_STAT, v);
        check(v & 32'hFF, {24'h0, 2'h2, ROLE_ADD, ROLE_ADD}, "add status");
        word <= 2'h1;
        repeat (3) wait_for(0);
        check({30'h0, add_bus_ch0_bit4, add_bus_ch0_bit3}, 32'h1, "add word 2");
    endtask
    task automatic t_hdlc;
        logic [31:0] v;
        role <= 2'h1;
        word <= 2'h1;
        wr(A_CTRL, 32'h0);
        repeat (2) wait_for(1);
        check({30'h0, hdlc_tx_ch0_bit4, hdlc_tx_ch0_bit3}, 32'h1, "hdlc byte");
        check_bit(hdlc_tx_ch0_clock, 1'b1, "hdlc clock");
        rd(A_STAT, v);
        check(v & 32'h3F, {26'h0, ROLE_HDLC, ROLE_HDLC}, "hdlc status");
        word <= 2'h2;
        repeat (2) wait_for(1);
        check({30'h0, hdlc_tx_ch0_bit4, hdlc_tx_ch0_bit3}, 32'h2, "hdlc byte 2");
    endtask
    task automatic t_trib_in;
        logic [31:0] v;
        int n;
        role <= 2'h2;
        word <= 2'h0;
        wr(A_CTRL, 32'h2);
        wr(A_EDGE, 32'h0);
        sent = 0;
        word <= 2'h1;
        n = 0;
        repeat (160)
        begin
            step(1);
            if (trib_add_strobe === 1'b1)
                n++;
            if (n == 40)
                word <= 2'h0;
        end
        rd(A_EDGE, v);
        check(v & 32'hFFFF, 32'(n), "edge count");
        check(32'(n), 32'(sent), "edges seen");
        check_bit(n >= 40, 1'b1, "enough edges");
        check_bit(shared_d3_oe | shared_d4_oe, 1'b0, "input oe");
        rd(A_STAT, v);
        check(v & 32'h3F, {26'h0, ROLE_NONE, ROLE_TRIB}, "mapper status");
    endtask
    task automatic t_trib_out;
        int n, r, h;
        role <= 2'h3;
        for (int t = 0; t < 3; t++)
        begin
            wr(A_CTRL, 32'(32'hA + 16 * t));
            r = (t == 0) ? RATE_DS3_KHZ : (t == 1) ? RATE_E3_KHZ : RATE_STS1_KHZ;
            h = HCLK_KHZ / (2 * r);
            h = (h < 1) ? 1 : h;
            step(4);
            check({30'h0, shared_d4_oe, shared_d3_oe}, 32'h1, "drop oe");
            n = 0;
            repeat (20)
            begin
                step(1);
                if (trib_drop_strobe === 1'b1)
                    n++;
            end
            check(32'(n), 32'(20 / (2 * h)), "drop clock rate");
        end
    endtask
    task automatic t_framer;
        logic [31:0] v;
        wr(A_CTRL, 32'h4);
        step(4);
        check({30'h0, shared_d4_oe, shared_d3_oe}, 32'h2, "framer oe");
        rd(A_STAT, v);
        check(v & 32'h3F, {26'h0, ROLE_OVH, ROLE_NONE}, "framer status");
        @(posedge hclk);
        tx_overhead_indicator_ch0 <= 1'b1;
        step(1);
        check_bit(shared_d4_out, 1'b1, "ovh high");
        tx_overhead_indicator_ch0 <= 1'b0;
        step(1);
        check_bit(shared_d4_out, 1'b0, "ovh low");
        wr(A_CTRL, 32'h6);
        step(4);
        check_bit(shared_d3_oe | shared_d4_oe, 1'b0, "idle oe");
    endtask
    // main sequence
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_add();
        t_hdlc();
        t_trib_in();
        t_trib_out();
        t_framer();
        summarize();
    end
    // watchdog against a hang
    initial
    begin
        #400000;
        num_errors++;
        summarize();
    end
endmodule // tx_ch0_shared_pin_mux_tb
